/* hw/cabe_pkg.sv */
// Shared constants and types for the branch and arithmetic execution unit.
package cabe_pkg;

	// Operation codes handed over by the decode stage.
	typedef enum logic [5:0] {
		OP_NONE                 = 6'h00,
		OP_BIT_CLEAR            = 6'h01,
		OP_TEST_REG             = 6'h02,
		OP_ZERO_REG             = 6'h03,
		OP_MULT_UU              = 6'h04,
		OP_MULT_SS              = 6'h05,
		OP_MULT_SU              = 6'h06,
		OP_FRAC_MULT_UU         = 6'h07,
		OP_FRAC_MULT_SS         = 6'h08,
		OP_FRAC_MULT_SU         = 6'h09,
		OP_CIPHER_ROUND         = 6'h0A,
		OP_REL_CALL             = 6'h0B,
		OP_IND_JUMP             = 6'h0C,
		OP_EXT_IND_JUMP         = 6'h0D,
		OP_IND_CALL             = 6'h0E,
		OP_EXT_IND_CALL         = 6'h0F,
		OP_CMP_SKIP_EQ          = 6'h10,
		OP_SKIP_REGBIT_CLR      = 6'h11,
		OP_SKIP_REGBIT_SET      = 6'h12,
		OP_SKIP_IOBIT_CLR       = 6'h13,
		OP_SKIP_IOBIT_SET       = 6'h14,
		OP_BRANCH_FLAG_SET      = 6'h15,
		OP_BRANCH_FLAG_CLR      = 6'h16,
		OP_BRANCH_SIGNED_GE     = 6'h17,
		OP_BRANCH_SIGNED_LT     = 6'h18,
		OP_BRANCH_UNSIGNED_GE   = 6'h19,
		OP_BRANCH_UNSIGNED_LT   = 6'h1A,
		OP_BRANCH_HALFCARRY_SET = 6'h1B,
		OP_BRANCH_HALFCARRY_CLR = 6'h1C,
		OP_BRANCH_OVF_SET       = 6'h1D,
		OP_BRANCH_OVF_CLR       = 6'h1E,
		OP_BRANCH_INT_ON        = 6'h1F,
		OP_BRANCH_INT_OFF       = 6'h20,
		OP_BRANCH_TBIT_SET      = 6'h21,
		OP_BRANCH_TBIT_CLR      = 6'h22
	} cabe_op_t;

	// Sequencer states, one-hot.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} cabe_state_t;

	// Bit positions inside the status flags word.
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// Program counter layout.
	localparam int PC_W     = 22;
	localparam int PC_LOW_W = 16;
	localparam int EXT_W    = 6;
	localparam int OFFS_W   = 12;

	// A wide program counter makes relative and indirect calls one cycle longer.
	localparam logic PC_IS_WIDE = 1'b1;

	// Cycle counts.
	localparam logic [2:0] CYC_ONE   = 3'h1;
	localparam logic [2:0] CYC_TWO   = 3'h2;
	localparam logic [2:0] CYC_THREE = 3'h3;
	localparam logic [2:0] CYC_FOUR  = 3'h4;

	// Register port offsets.
	localparam logic [3:0] REG_EXT_IND = 4'h0;
	localparam logic [3:0] REG_FLAGS   = 4'h1;
	localparam logic [3:0] REG_STATUS  = 4'h2;

	// Values after reset.
	localparam logic [5:0] EXT_IND_RST = 6'h00;
	localparam logic [7:0] FLAGS_RST   = 8'h00;

endpackage

/* hw/cabe_cipher_round.sv */
// One Feistel round over the 64-bit block and 64-bit key held in the register file.
`timescale 1ns/1ns
`default_nettype none

module cabe_cipher_round (
	// Round control.
	input  wire logic         decrypt,
	input  wire logic [3:0]   key_idx,
	// State in and out: bits 63:0 data, bits 127:64 key.
	input  wire logic [127:0] state_in,
	output logic      [127:0] state_out
);

	logic [63:0] key;
	logic [63:0] key_rot;
	logic [31:0] left;
	logic [31:0] right;
	logic [31:0] f_in;
	logic [31:0] f_out;

	// Split the block and rotate the key by the round index.
	assign key     = state_in[127:64];
	assign key_rot = (key << key_idx) | (key >> (7'd64 - {3'h0, key_idx}));
	assign left    = state_in[63:32];
	assign right   = state_in[31:0];

	// Encryption runs the round function on the right half, decryption on the left.
	assign f_in  = decrypt ? left : right;
	assign f_out = {f_in[26:0], f_in[31:27]} ^ key_rot[31:0] ^ (f_in & key_rot[63:32]);

	// Swap halves forward on encrypt and backward on decrypt.
	assign state_out = decrypt ? {key, right ^ f_out, left} : {key, right, left ^ f_out};

endmodule

`default_nettype wire

/* hw/cabe_exec.sv */
// Execution unit for bit clear, multiply, cipher round, indirect jumps, calls, skips and branches.
//
// What this block does
// - Bit clear writes Rd AND NOT mask; updates Z N V S; one cycle.
// - Test ANDs Rd with itself; clear XORs Rd to zero; one cycle each.
// - Multiply writes 16-bit product to the product pair; only Z C; two cycles.
// - Fractional multiply shifts product left one bit; only Z C; two cycles.
// - Cipher round encrypts when H clear, decrypts when H set; one or two cycles.
// - Relative call pushes return address, jumps to PC plus offset plus one.
// - Indirect jump loads low PC from Z and clears high PC; two cycles.
// - Extended indirect jump takes high PC from extended register; two cycles.
// - Indirect call pushes return, loads low PC from Z, zeroes high PC.
// - Extended indirect call pushes return, high PC from extended register; three cycles.
// - Compare-skip advances PC two or three words when registers match.
// - Register bit skips skip next instruction on bit clear or set.
// - I/O bit skips test one I/O bit; one cycle longer than register skips.
// - Flag branches jump to PC plus offset plus one on selected flag state.
// - Signed greater-or-equal branch taken when N XOR V is zero.
// - Signed less-than branch taken when N XOR V is one.
// - Unsigned same-or-higher taken on carry clear, lower taken on carry set.
// - Half-carry branches taken on H set or H clear.
// - Overflow branches taken on V set or V clear.
// - Interrupt-state branches taken on global interrupt enable set or clear.
// - Transfer-bit branches taken on T set or T clear.
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module cabe_exec (
	// Clock and reset.
	input  wire logic                          clk_sys,
	input  wire logic                          rst_b,
	// Issue from the decode stage.
	input  wire logic                          issue,
	input  wire cabe_pkg::cabe_op_t            op,
	input  wire logic [7:0]                    rd_val,
	input  wire logic [7:0]                    rr_val,
	input  wire logic [7:0]                    imm_val,
	input  wire logic [2:0]                    bit_sel,
	input  wire logic [2:0]                    flag_sel,
	input  wire logic                          io_bit,
	input  wire logic [cabe_pkg::OFFS_W-1:0]   rel_offset,
	input  wire logic                          next_two_words,
	input  wire logic [cabe_pkg::PC_W-1:0]     pc_cur,
	input  wire logic [15:0]                   z_ptr,
	input  wire logic [3:0]                    cipher_key_idx,
	input  wire logic [127:0]                  cipher_state_in,
	input  wire logic [7:0]                    flags_in,
	// Register port.
	input  wire logic [3:0]                    reg_addr,
	input  wire logic [7:0]                    reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [7:0]                    reg_rdata,
	// Sequencer status.
	output logic                               busy,
	output logic                               done,
	// Register file write back.
	output logic                               rd_wr_en,
	output logic      [7:0]                    rd_wr_data,
	output logic                               pair_wr_en,
	output logic      [15:0]                   pair_wr_data,
	output logic                               cipher_wr_en,
	output logic      [127:0]                  cipher_state_out,
	output logic                               flags_wr_en,
	output logic      [7:0]                    flags_out,
	// Program flow.
	output logic                               pc_load,
	output logic      [cabe_pkg::PC_W-1:0]     pc_next,
	output logic                               push_en,
	output logic      [cabe_pkg::PC_W-1:0]     push_addr
);

	cabe_pkg::cabe_state_t state_q;
	logic [2:0]                   cnt_q;
	cabe_pkg::cabe_op_t           op_q;
	logic [cabe_pkg::EXT_W-1:0]   ext_ind_q;
	logic                         prev_cipher_q;
	logic                         taken_last_q;
	logic                         pend_rd_q;
	logic                         pend_pair_q;
	logic                         pend_cipher_q;
	logic                         pend_flags_q;
	logic                         pend_push_q;
	logic                         busy_q;
	logic                         done_q;
	logic                         rd_wr_en_q;
	logic                         pair_wr_en_q;
	logic                         cipher_wr_en_q;
	logic                         flags_wr_en_q;
	logic                         pc_load_q;
	logic                         push_en_q;
	logic [7:0]                   rd_wr_data_q;
	logic [15:0]                  pair_wr_data_q;
	logic [127:0]                 cipher_q;
	logic [7:0]                   flags_q;
	logic [cabe_pkg::PC_W-1:0]    pc_next_q;
	logic [cabe_pkg::PC_W-1:0]    push_addr_q;
	logic [7:0]                   reg_rdata_q;

	// Request acceptance and completion.
	logic take;
	logic finish;
	assign take   = issue & (state_q == cabe_pkg::ST_IDLE);
	assign finish = (state_q == cabe_pkg::ST_RUN) & (cnt_q == cabe_pkg::CYC_ONE);

	// Targets: sequential, skip, relative and indirect.
	logic [cabe_pkg::PC_W-1:0] pc_plus1;
	logic [cabe_pkg::PC_W-1:0] pc_skip;
	logic [cabe_pkg::PC_W-1:0] pc_rel;
	logic [cabe_pkg::PC_W-1:0] pc_ind;
	logic [cabe_pkg::PC_W-1:0] pc_ext;
	assign pc_plus1 = pc_cur + 22'h000001;
	assign pc_skip  = pc_cur + (next_two_words ? 22'h000003 : 22'h000002);
	assign pc_rel   = pc_cur + {{10{rel_offset[11]}}, rel_offset} + 22'h000001;
	assign pc_ind   = {6'h00, z_ptr};
	assign pc_ext   = {ext_ind_q, z_ptr};

	// Logic results share one flag update: V cleared, S equals N.
	logic [7:0] logic_res;
	logic [7:0] logic_flags;
	assign logic_res = (op == cabe_pkg::OP_BIT_CLEAR) ? (rd_val & ~imm_val) :
		(op == cabe_pkg::OP_ZERO_REG) ? (rd_val ^ rd_val) : (rd_val & rd_val);
	assign logic_flags = {flags_in[7:5], logic_res[7], 1'b0, logic_res[7], (logic_res == 8'h00), flags_in[0]};

	// Multiply with per-variant operand signedness via sign extension.
	logic       mul_a_sgn;
	logic       mul_b_sgn;
	logic       mul_frac;
	logic [17:0] mul_a;
	logic [17:0] mul_b;
	logic [17:0] mul_full;
	logic [15:0] mul_prod;
	logic [15:0] mul_res;
	logic [7:0]  mul_flags;
	assign mul_a_sgn = (op == cabe_pkg::OP_MULT_SS) | (op == cabe_pkg::OP_MULT_SU) |
		(op == cabe_pkg::OP_FRAC_MULT_SS) | (op == cabe_pkg::OP_FRAC_MULT_SU);
	assign mul_b_sgn = (op == cabe_pkg::OP_MULT_SS) | (op == cabe_pkg::OP_FRAC_MULT_SS);
	assign mul_frac  = (op == cabe_pkg::OP_FRAC_MULT_UU) | (op == cabe_pkg::OP_FRAC_MULT_SS) |
		(op == cabe_pkg::OP_FRAC_MULT_SU);
	// Operands are extended to the full width first, so no product bit is lost to a narrow context.
	assign mul_a     = {{10{mul_a_sgn & rd_val[7]}}, rd_val};
	assign mul_b     = {{10{mul_b_sgn & rr_val[7]}}, rr_val};
	assign mul_full  = mul_a * mul_b;
	assign mul_prod  = mul_full[15:0];
	assign mul_res   = mul_frac ? {mul_prod[14:0], 1'b0} : mul_prod;
	assign mul_flags = {flags_in[7:2], (mul_res == 16'h0000), mul_prod[15]};

	// Cipher round; the half-carry flag picks the direction.
	logic [127:0] cipher_res;
	cabe_cipher_round u_round (
		.decrypt   (flags_in[cabe_pkg::FLAG_H]),
		.key_idx   (cipher_key_idx),
		.state_in  (cipher_state_in),
		.state_out (cipher_res)
	);

	// Conditions for skips and branches.
	logic flag_sel_bit;
	logic reg_bit;
	logic sign_lt;
	assign flag_sel_bit = flags_in[flag_sel];
	assign reg_bit      = rr_val[bit_sel];
	assign sign_lt      = flags_in[cabe_pkg::FLAG_N] ^ flags_in[cabe_pkg::FLAG_V];

	// Per-operation decode of cycles, write back and next program counter.
	logic [2:0]                cyc_d;
	logic                      cond_d;
	logic                      is_skip;
	logic                      is_branch;
	logic                      wr_rd_d;
	logic                      wr_pair_d;
	logic                      wr_cipher_d;
	logic                      wr_flags_d;
	logic                      push_d;
	logic [cabe_pkg::PC_W-1:0] pc_d;
	always_comb begin
		cond_d    = 1'b0;
		is_skip   = 1'b0;
		is_branch = 1'b0;
		case (op)
			cabe_pkg::OP_CMP_SKIP_EQ: begin
				is_skip = 1'b1;
				cond_d  = (rd_val == rr_val);
			end
			cabe_pkg::OP_SKIP_REGBIT_CLR, cabe_pkg::OP_SKIP_IOBIT_CLR: begin
				is_skip = 1'b1;
				cond_d  = (op == cabe_pkg::OP_SKIP_IOBIT_CLR) ? ~io_bit : ~reg_bit;
			end
			cabe_pkg::OP_SKIP_REGBIT_SET, cabe_pkg::OP_SKIP_IOBIT_SET: begin
				is_skip = 1'b1;
				cond_d  = (op == cabe_pkg::OP_SKIP_IOBIT_SET) ? io_bit : reg_bit;
			end
			cabe_pkg::OP_BRANCH_FLAG_SET: begin
				is_branch = 1'b1;
				cond_d    = flag_sel_bit;
			end
			cabe_pkg::OP_BRANCH_FLAG_CLR: begin
				is_branch = 1'b1;
				cond_d    = ~flag_sel_bit;
			end
			cabe_pkg::OP_BRANCH_SIGNED_GE: begin
				is_branch = 1'b1;
				cond_d    = ~sign_lt;
			end
			cabe_pkg::OP_BRANCH_SIGNED_LT: begin
				is_branch = 1'b1;
				cond_d    = sign_lt;
			end
			cabe_pkg::OP_BRANCH_UNSIGNED_GE, cabe_pkg::OP_BRANCH_UNSIGNED_LT: begin
				is_branch = 1'b1;
				cond_d    = flags_in[cabe_pkg::FLAG_C] ^ (op == cabe_pkg::OP_BRANCH_UNSIGNED_GE);
			end
			cabe_pkg::OP_BRANCH_HALFCARRY_SET, cabe_pkg::OP_BRANCH_HALFCARRY_CLR: begin
				is_branch = 1'b1;
				cond_d    = flags_in[cabe_pkg::FLAG_H] ^ (op == cabe_pkg::OP_BRANCH_HALFCARRY_CLR);
			end
			cabe_pkg::OP_BRANCH_OVF_SET, cabe_pkg::OP_BRANCH_OVF_CLR: begin
				is_branch = 1'b1;
				cond_d    = flags_in[cabe_pkg::FLAG_V] ^ (op == cabe_pkg::OP_BRANCH_OVF_CLR);
			end
			cabe_pkg::OP_BRANCH_INT_ON, cabe_pkg::OP_BRANCH_INT_OFF: begin
				is_branch = 1'b1;
				cond_d    = flags_in[cabe_pkg::FLAG_I] ^ (op == cabe_pkg::OP_BRANCH_INT_OFF);
			end
			cabe_pkg::OP_BRANCH_TBIT_SET, cabe_pkg::OP_BRANCH_TBIT_CLR: begin
				is_branch = 1'b1;
				cond_d    = flags_in[cabe_pkg::FLAG_T] ^ (op == cabe_pkg::OP_BRANCH_TBIT_CLR);
			end
			default: begin
				cond_d = 1'b0;
			end
		endcase
	end

	// Cycle counts, write back and next program counter per class.
	logic is_logic;
	logic is_mul;
	logic is_call;
	logic io_skip;
	assign is_logic = (op == cabe_pkg::OP_BIT_CLEAR) | (op == cabe_pkg::OP_TEST_REG) | (op == cabe_pkg::OP_ZERO_REG);
	assign is_mul   = (op >= cabe_pkg::OP_MULT_UU) & (op <= cabe_pkg::OP_FRAC_MULT_SU);
	assign is_call  = (op == cabe_pkg::OP_REL_CALL) | (op == cabe_pkg::OP_IND_CALL) | (op == cabe_pkg::OP_EXT_IND_CALL);
	assign io_skip  = (op == cabe_pkg::OP_SKIP_IOBIT_CLR) | (op == cabe_pkg::OP_SKIP_IOBIT_SET);

	always_comb begin
		wr_rd_d     = is_logic;
		wr_pair_d   = is_mul;
		wr_cipher_d = (op == cabe_pkg::OP_CIPHER_ROUND);
		wr_flags_d  = is_logic | is_mul;
		push_d      = is_call;
		pc_d        = pc_plus1;
		cyc_d       = cabe_pkg::CYC_ONE;
		if (is_mul) begin
			cyc_d = cabe_pkg::CYC_TWO;
		end else if (op == cabe_pkg::OP_CIPHER_ROUND) begin
			cyc_d = prev_cipher_q ? cabe_pkg::CYC_ONE : cabe_pkg::CYC_TWO;
		end else if (op == cabe_pkg::OP_REL_CALL || op == cabe_pkg::OP_IND_CALL) begin
			pc_d  = (op == cabe_pkg::OP_REL_CALL) ? pc_rel : pc_ind;
			cyc_d = cabe_pkg::PC_IS_WIDE ? cabe_pkg::CYC_THREE : cabe_pkg::CYC_TWO;
		end else if (op == cabe_pkg::OP_EXT_IND_CALL) begin
			pc_d  = pc_ext;
			cyc_d = cabe_pkg::CYC_THREE;
		end else if (op == cabe_pkg::OP_IND_JUMP || op == cabe_pkg::OP_EXT_IND_JUMP) begin
			pc_d  = (op == cabe_pkg::OP_IND_JUMP) ? pc_ind : pc_ext;
			cyc_d = cabe_pkg::CYC_TWO;
		end else if (is_skip) begin
			pc_d  = cond_d ? pc_skip : pc_plus1;
			cyc_d = !cond_d ? cabe_pkg::CYC_ONE : (next_two_words ? cabe_pkg::CYC_THREE : cabe_pkg::CYC_TWO);
			if (io_skip) begin
				cyc_d = cyc_d + cabe_pkg::CYC_ONE;
			end
		end else if (is_branch) begin
			pc_d  = cond_d ? pc_rel : pc_plus1;
			cyc_d = cond_d ? cabe_pkg::CYC_TWO : cabe_pkg::CYC_ONE;
		end
	end

	// Register port decode; unmapped offsets read as zero.
	logic [7:0] reg_rd_mux;
	assign reg_rd_mux = (reg_addr == cabe_pkg::REG_EXT_IND) ? {2'h0, ext_ind_q} :
		(reg_addr == cabe_pkg::REG_FLAGS) ? flags_q :
		(reg_addr == cabe_pkg::REG_STATUS) ? {5'h00, taken_last_q, prev_cipher_q, busy_q} : 8'h00;

	// Register port: extended register writes, read data for one cycle.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ext_ind_q   <= cabe_pkg::EXT_IND_RST;
			reg_rdata_q <= 8'h00;
		end else begin
			if (reg_wr && reg_addr == cabe_pkg::REG_EXT_IND) begin
				ext_ind_q <= reg_wdata[5:0];
			end
			reg_rdata_q <= reg_rd ? reg_rd_mux : 8'h00;
		end
	end

	// Sequencer: capture results on take, count down, pulse the strobes on finish.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= cabe_pkg::ST_IDLE;
			cnt_q   <= 3'h0;
			op_q    <= cabe_pkg::OP_NONE;
			busy_q  <= 1'b0;
		end else if (take) begin
			state_q <= cabe_pkg::ST_RUN;
			cnt_q   <= cyc_d;
			op_q    <= op;
			busy_q  <= 1'b1;
		end else if (finish) begin
			state_q <= cabe_pkg::ST_IDLE;
			busy_q  <= 1'b0;
		end else if (state_q == cabe_pkg::ST_RUN) begin
			cnt_q <= cnt_q - cabe_pkg::CYC_ONE;
		end
	end

	// Results captured when an operation is taken.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			{pend_rd_q, pend_pair_q, pend_cipher_q, pend_flags_q, pend_push_q} <= 5'h00;
			rd_wr_data_q   <= 8'h00;
			pair_wr_data_q <= 16'h0000;
			cipher_q       <= 128'h0;
			pc_next_q      <= 22'h000000;
			push_addr_q    <= 22'h000000;
			taken_last_q   <= 1'b0;
		end else if (take) begin
			{pend_rd_q, pend_pair_q, pend_cipher_q, pend_flags_q, pend_push_q} <=
				{wr_rd_d, wr_pair_d, wr_cipher_d, wr_flags_d, push_d};
			rd_wr_data_q   <= logic_res;
			pair_wr_data_q <= mul_res;
			cipher_q       <= cipher_res;
			pc_next_q      <= pc_d;
			push_addr_q    <= pc_plus1;
			taken_last_q   <= cond_d;
		end
	end

	// Flags, held readable after completion.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			flags_q <= cabe_pkg::FLAGS_RST;
		end else if (take && wr_flags_d) begin
			flags_q <= is_mul ? mul_flags : logic_flags;
		end
	end

	// One-cycle strobes and the back-to-back cipher marker.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			{done_q, rd_wr_en_q, pair_wr_en_q, cipher_wr_en_q, flags_wr_en_q, pc_load_q, push_en_q} <= 7'h00;
			prev_cipher_q <= 1'b0;
		end else begin
			{done_q, rd_wr_en_q, pair_wr_en_q, cipher_wr_en_q, flags_wr_en_q, pc_load_q, push_en_q} <=
				{7{finish}} & {1'b1, pend_rd_q, pend_pair_q, pend_cipher_q, pend_flags_q, 1'b1, pend_push_q};
			if (finish) begin
				prev_cipher_q <= (op_q == cabe_pkg::OP_CIPHER_ROUND);
			end
		end
	end

	// Outputs straight from flip-flops.
	assign reg_rdata        = reg_rdata_q;
	assign busy             = busy_q;
	assign done             = done_q;
	assign rd_wr_en         = rd_wr_en_q;
	assign rd_wr_data       = rd_wr_data_q;
	assign pair_wr_en       = pair_wr_en_q;
	assign pair_wr_data     = pair_wr_data_q;
	assign cipher_wr_en     = cipher_wr_en_q;
	assign cipher_state_out = cipher_q;
	assign flags_wr_en      = flags_wr_en_q;
	assign flags_out        = flags_q;
	assign pc_load          = pc_load_q;
	assign pc_next          = pc_next_q;
	assign push_en          = push_en_q;
	assign push_addr        = push_addr_q;

	// Checks on the executed behaviour.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	bit_clear_res_a: assert property (
		take && op == cabe_pkg::OP_BIT_CLEAR |-> ##2 rd_wr_en && rd_wr_data == ($past(rd_val, 2) & ~$past(imm_val, 2)))
		else $error("bit clear result or timing wrong");
	zero_reg_res_a: assert property (
		take && op == cabe_pkg::OP_ZERO_REG |-> ##2 rd_wr_en && rd_wr_data == 8'h00 && flags_out[cabe_pkg::FLAG_Z])
		else $error("clear did not zero the register");
	mult_timing_a: assert property (
		take && op == cabe_pkg::OP_MULT_UU |-> ##1 !done ##1 !done ##1 pair_wr_en &&
		pair_wr_data == 16'($past(rd_val, 3)) * 16'($past(rr_val, 3)))
		else $error("unsigned multiply result or timing wrong");
	frac_shift_a: assert property (
		take && op == cabe_pkg::OP_FRAC_MULT_UU |-> ##3 pair_wr_en &&
		pair_wr_data == ((16'($past(rd_val, 3)) * 16'($past(rr_val, 3))) << 1))
		else $error("fractional multiply not shifted");
	ind_jump_high_a: assert property (
		done && op_q == cabe_pkg::OP_IND_JUMP |-> pc_load && pc_next[21:16] == 6'h00)
		else $error("indirect jump left high bits set");
	ext_jump_high_a: assert property (
		take && op == cabe_pkg::OP_EXT_IND_JUMP && !reg_wr |-> ##3 pc_load && pc_next[21:16] == $past(ext_ind_q, 3))
		else $error("extended jump high bits wrong");
	ext_call_push_a: assert property (
		take && op == cabe_pkg::OP_EXT_IND_CALL |-> ##1 busy [*3] ##1 (push_en && push_addr == $past(pc_cur, 4) + 22'h000001))
		else $error("extended call did not push in three cycles");
	signed_ge_br_a: assert property (
		take && op == cabe_pkg::OP_BRANCH_SIGNED_GE && !(flags_in[2] ^ flags_in[3]) |-> ##3 pc_load &&
		pc_next == $past(pc_cur, 3) + {{10{$past(rel_offset[11], 3)}}, $past(rel_offset, 3)} + 22'h000001)
		else $error("signed branch target wrong");
	io_skip_cyc_a: assert property (
		take && op == cabe_pkg::OP_SKIP_IOBIT_SET && !io_bit |-> ##1 !done ##1 !done ##1 done &&
		pc_next == $past(pc_cur, 3) + 22'h000001)
		else $error("untaken I/O skip took wrong time");

endmodule

`default_nettype wire

/* testbench/tb_cabe_exec.sv */
// Self-checking bench for the execution unit.
`timescale 1ns/1ns
`default_nettype none
module tb_cabe_exec;
	logic clk_sys, rst_b, issue, io_bit, next_two_words, reg_wr, reg_rd, busy, done, rd_wr_en, pair_wr_en;
	logic cipher_wr_en, flags_wr_en, pc_load, push_en, s;
	cabe_pkg::cabe_op_t op;
	logic [7:0] rd_val, rr_val, imm_val, flags_in, reg_wdata, reg_rdata, rd_wr_data, flags_out, r, f;
	logic [2:0] bit_sel, flag_sel;
	logic [11:0] rel_offset;
	logic [21:0] pc_cur, pc_next, push_addr, e;
	logic [15:0] z_ptr, pair_wr_data;
	logic [3:0] cipher_key_idx, reg_addr;
	logic [127:0] cipher_state_in, cipher_state_out, cs;
	logic [5:0] o, ext;
	logic [31:0] x;
	int error_cnt, tests_run, n, a, b, p, q, k;
	cabe_exec i_dut (.*);
	// Compare and count.
	task chk(input logic [31:0] g, input logic [31:0] w);
		tests_run++;
		if (g !== w) begin
			error_cnt++;
			$display("[ERR] %0t got %0h exp %0h", $time, g, w);
		end
	endtask
	task complete_run;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Register port cycles.
	task rw(input logic [3:0] ad, input logic [7:0] d);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys) reg_wr <= 1'b0;
	endtask
	task rr(input logic [3:0] ad, input logic [7:0] w);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clk_sys) reg_rd <= 1'b0;
		#1 chk(reg_rdata, w);
	endtask
	// Issue one op and count edges from take to done.
	task run(input logic [5:0] c);
		op <= cabe_pkg::cabe_op_t'(c);
		issue <= 1'b1;
		@(posedge clk_sys) issue <= 1'b0;
		n = 1;
		#1 while (done !== 1'b1 && n < 9) begin
			@(posedge clk_sys);
			#1 n++;
		end
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Watchdog well beyond the expected run length.
	initial begin
		#100000;
		error_cnt++;
		complete_run();
	end
	initial begin
		{issue, io_bit, next_two_words, reg_wr, reg_rd, rd_val, rr_val, imm_val, flags_in, reg_wdata} = '0;
		{bit_sel, flag_sel, rel_offset, pc_cur, z_ptr, cipher_key_idx, reg_addr, cipher_state_in} = '0;
		op = cabe_pkg::OP_NONE;
		rst_b = 1'b0;
		x = $urandom(32'hAC83370A);
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		#1 chk({busy, done, pc_next, flags_out}, 32'h0);
		ext = $urandom;
		rw(4'h0, {2'h3, ext});
		rr(4'h0, {2'h0, ext});
		rr(4'hF, 8'h00);
		$display("register test done");
		for (int i = 0; i < 24; i++) begin
			rd_val <= $urandom;
			imm_val <= $urandom;
			flags_in <= $urandom;
			run(6'h1 + i % 3);
			chk(n, 2);
			r = (i % 3 == 0) ? rd_val & ~imm_val : (i % 3 == 1) ? rd_val : 8'h00;
			chk(rd_wr_data, r);
			chk({rd_wr_en, flags_wr_en, pc_load, pair_wr_en, push_en}, 5'b11100);
			chk(flags_out, {flags_in[7:5], r[7], 1'b0, r[7], r == 8'h00, flags_in[0]});
		end
		$display("logic test done");
		for (int i = 0; i < 30; i++) begin
			rd_val <= $urandom;
			rr_val <= $urandom;
			o = 4 + i % 6;
			run(o);
			chk(n, 3);
			k = (o - 4) % 3;
			a = rd_val;
			if (k != 0) a = $signed(rd_val);
			b = rr_val;
			if (k == 1) b = $signed(rr_val);
			q = a * b;
			p = q << (o > 6);
			chk(pair_wr_data, p[15:0]);
			chk(flags_out, {flags_in[7:2], p[15:0] == 16'h0, q[15]});
			chk({rd_wr_en, pair_wr_en, flags_wr_en, busy}, 4'b0110);
		end
		rr(4'h1, {flags_in[7:2], p[15:0] == 16'h0, q[15]});
		$display("multiply test done");
		for (int i = 0; i < 20; i++) begin
			o = 11 + i % 5;
			pc_cur <= $urandom;
			z_ptr <= $urandom;
			rel_offset <= $urandom;
			run(o);
			chk(n, (o == 12 || o == 13) ? 3 : 4);
			e = (o == 11) ? pc_cur + {{10{rel_offset[11]}}, rel_offset} + 1 : {(o == 13 || o == 15) ? ext : 6'h0, z_ptr};
			chk(pc_next, e);
			chk(push_en, o == 11 || o > 13);
			if (push_en) chk(push_addr, pc_cur + 22'h1);
		end
		$display("jump test done");
		for (int i = 0; i < 40; i++) begin
			o = 16 + i % 5;
			x = $urandom;
			rd_val <= x[7:0];
			rr_val <= i[3] ? x[7:0] : x[15:8];
			{bit_sel, io_bit, next_two_words} <= x[20:16];
			run(o);
			s = (o == 16) ? rd_val == rr_val : (o == 17) ? !rr_val[bit_sel] : (o == 18) ? rr_val[bit_sel] : io_bit ^ (o == 19);
			chk(n, 2 + (o > 18) + (s ? 1 + next_two_words : 0));
			e = pc_cur + 22'h1 + (s ? 1 + next_two_words : 0);
			chk(pc_next, e);
		end
		$display("skip test done");
		for (int i = 0; i < 70; i++) begin
			o = 21 + i % 14;
			x = $urandom;
			flags_in <= x[7:0];
			flag_sel <= x[10:8];
			rel_offset <= x[31:20];
			pc_cur <= $urandom;
			run(o);
			f = flags_in;
			case (o)
				21, 22: s = f[flag_sel];
				23, 24: s = f[2] ^ f[3];
				25, 26: s = f[0];
				27, 28: s = f[5];
				29, 30: s = f[3];
				31, 32: s = f[7];
				default: s = f[6];
			endcase
			s = s ^ ((o % 2 == 0) ^ (o inside {[23:26]}));
			chk(n, 2 + s);
			e = pc_cur + 22'h1 + (s ? {{10{rel_offset[11]}}, rel_offset} : 22'h0);
			chk(pc_next, e);
		end
		rr(4'h2, {5'h00, s, 2'b00});
		$display("branch test done");
		// Encrypt a random block, then decrypt the result with the same key index.
		for (int i = 0; i < 6; i++) begin
			if (!i[0]) begin
				cs = {$urandom, $urandom, $urandom, $urandom};
				cipher_key_idx <= $urandom;
			end
			cipher_state_in <= i[0] ? cipher_state_out : cs;
			flags_in <= {2'h0, i[0], 5'h00};
			run(6'h0A);
			chk(n, (i == 0) ? 3 : 2);
			chk(cipher_wr_en, 1);
			for (int j = 0; j < 4; j++) if (i[0] || j > 1) chk(cipher_state_out[j*32+:32], cs[j*32+:32]);
		end
		$display("cipher test done");
		complete_run();
	end
endmodule
`default_nettype wire
